// File: rtl/dma_port_pkg.sv
// Constants and carrier types for the DMA-side buffer port access logic.
package dma_port_pkg;

   localparam logic [7:0] PORT0_CONTROL_OFS = 8'h4A;
   localparam logic [7:0] PORT0_DATA_OFS = 8'h4C;
   localparam logic [7:0] PORT1_CONTROL_OFS = 8'h52;
   localparam logic [7:0] PORT1_DATA_OFS = 8'h54;

   localparam logic [15:0] CONTROL_RESET = 16'h0800;
   localparam int TXN_CLEAR_BIT = 15;
   localparam int TXN_ENABLE_BIT = 14;
   localparam int VALID_BIT = 13;
   localparam int CLEAR_BIT = 12;
   localparam int NOT_READY_BIT = 11;

   localparam int LEN_W = 11;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_CNT_W = 4;

   localparam logic [3:0] EP_FIRST = 4'h1;
   localparam logic [3:0] EP_LAST = 4'h6;

   // Port select fields that steer one port.
   typedef struct packed {
      logic burst_select;
      logic ready_flag_timing;
      logic dma_request_enable;
      logic byte_swap;
      logic byte_mode;
      logic [3:0] dma_endpoint_select;
   } port_cfg_t;

   // One buffer word; data[7:0] is the earlier byte on the wire.
   typedef struct packed {
      logic last;
      logic single;
      logic [15:0] data;
   } stream_word_t;

endpackage : dma_port_pkg

// File: rtl/dma_fifo_port_access.sv
// Buffer FIFO and the two DMA-side port access blocks of the device.
`timescale 1ns/1ps

module port_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8,
   parameter int CNT_W = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [CNT_W-1:0] count
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic push;
   logic pop;

   assign in_ready = (count_q != CNT_W'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data = mem[rd_ptr_q];
   assign count = count_q;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
      end
   end

endmodule : port_fifo

module dma_fifo_port_access #(
   parameter int FIFO_DEPTH = dma_port_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Parallel register bus
   input wire logic bus_cs,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_addr,
   input wire logic [1:0] bus_be,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   // Port select fields, strap and endpoint configuration
   input dma_port_pkg::port_cfg_t port_cfg [2],
   input wire logic bus_width_strap,
   input wire logic [6:0] endpoint_byte_mode,
   input wire logic [6:0] endpoint_direction,
   output logic [1:0] byte_mode_readback,
   // DMA controller side
   input wire logic [1:0] terminal_count_in,
   output logic [1:0] dma_request,
   // Transaction counter and buffer-ready events
   output logic [1:0] txn_count_enable,
   output logic [1:0] txn_count_clear,
   output logic [1:0] buffer_ready_flag,
   // Serial engine receive stream
   input wire logic [1:0] sie_rx_valid,
   input dma_port_pkg::stream_word_t sie_rx_word [2],
   output logic [1:0] sie_rx_ready,
   // Serial engine transmit stream
   output logic [1:0] sie_tx_valid,
   output dma_port_pkg::stream_word_t sie_tx_word [2],
   input wire logic [1:0] sie_tx_ready
);
   localparam int FW = $bits(dma_port_pkg::stream_word_t);
   localparam int LW = dma_port_pkg::LEN_W;
   localparam int CW = dma_port_pkg::FIFO_CNT_W;

   logic [15:0] rd_val [2];
   logic [15:0] bus_rdata_q;
   logic [7:0] ep_dir_vec;
   logic [7:0] ep_bm_vec;

   // The strap is low for an 8-bit bus.
   logic strap_narrow;

   assign strap_narrow = ~bus_width_strap;
   assign ep_dir_vec = {1'b0, endpoint_direction};
   assign ep_bm_vec = {1'b0, endpoint_byte_mode};
   assign bus_rdata = bus_rdata_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus_rdata_q <= 16'h0000;
      end else if (bus_cs && bus_rd) begin
         bus_rdata_q <= rd_val[0] | rd_val[1];
      end
   end

   for (genvar g = 0; g < 2; g++) begin : port_g
      localparam logic [7:0] CTRL_OFS =
         (g == 0) ? dma_port_pkg::PORT0_CONTROL_OFS : dma_port_pkg::PORT1_CONTROL_OFS;
      localparam logic [7:0] DATA_OFS =
         (g == 0) ? dma_port_pkg::PORT0_DATA_OFS : dma_port_pkg::PORT1_DATA_OFS;

      dma_port_pkg::port_cfg_t cfg;
      dma_port_pkg::stream_word_t fill_word;
      dma_port_pkg::stream_word_t bus_word;
      dma_port_pkg::stream_word_t head;
      logic [3:0] ep;
      logic ep_ok;
      logic is_tx;
      logic narrow;
      logic not_ready;
      logic hit_ctrl;
      logic hit_data;
      logic ctrl_wr;
      logic data_wr;
      logic data_rd;
      logic fill_valid;
      logic fill_ready;
      logic drain_valid;
      logic drain_ready;
      logic [CW-1:0] fcount;
      logic rx_push;
      logic rx_pop;
      logic tx_pop;
      logic tx_done;
      logic clear_req;
      logic flush;
      logic force_done;
      logic fill_done;
      logic [15:0] head_data;
      logic [15:0] ctrl_word;
      logic [15:0] data_word;
      logic valid_q;
      logic half_q;
      logic access_q;
      logic txn_en_q;
      logic txn_clr_q;
      logic ready_q;
      logic [LW-1:0] len_q;
      logic [LW-1:0] push_bytes;
      logic [LW-1:0] pop_bytes;

      assign cfg = port_cfg[g];
      assign ep = cfg.dma_endpoint_select;
      assign ep_ok = (ep >= dma_port_pkg::EP_FIRST) && (ep <= dma_port_pkg::EP_LAST);
      assign is_tx = ep_ok & ep_dir_vec[ep[2:0]];
      assign narrow = strap_narrow | cfg.byte_mode | ep_bm_vec[ep[2:0]];
      assign byte_mode_readback[g] = cfg.byte_mode & ~strap_narrow;

      // Not ready: no endpoint, a finished or full transmit buffer, or nothing to read.
      always_comb begin
         if (!ep_ok) begin
            not_ready = 1'b1;
         end else if (is_tx) begin
            not_ready = valid_q | ~fill_ready;
         end else begin
            not_ready = ~valid_q | ~drain_valid;
         end
      end

      assign hit_ctrl = bus_cs && (bus_addr == CTRL_OFS);
      assign hit_data = bus_cs && (bus_addr == DATA_OFS);
      assign ctrl_wr = hit_ctrl & bus_wr & bus_be[1];
      // Accesses while not ready are dropped rather than corrupting the buffer.
      assign data_wr = hit_data & bus_wr & is_tx & ~not_ready;
      assign data_rd = hit_data & bus_rd & ~is_tx & ~not_ready;

      // Build a transmit word from the bus, honouring width and byte order.
      always_comb begin
         bus_word.last = 1'b0;
         bus_word.single = 1'b1;
         bus_word.data = {8'h00, bus_wdata[7:0]};
         if (!narrow) begin
            if (bus_be == 2'b11) begin
               bus_word.single = 1'b0;
               bus_word.data = cfg.byte_swap ? {bus_wdata[7:0], bus_wdata[15:8]} : bus_wdata;
            end else if (bus_be[1]) begin
               bus_word.data = {8'h00, bus_wdata[15:8]};
            end
         end
      end

      assign fill_word = is_tx ? bus_word : sie_rx_word[g];
      // Receive fills only on a real handshake, so an unselected port never takes a word.
      assign fill_valid = is_tx ? data_wr : rx_push;
      assign sie_rx_ready[g] = ~is_tx & ep_ok & fill_ready & ~valid_q;
      assign rx_push = ~is_tx & sie_rx_valid[g] & sie_rx_ready[g];

      // Transmit drains only once the packet is marked complete.
      assign drain_ready = is_tx ? (sie_tx_ready[g] & valid_q) : rx_pop;
      assign sie_tx_valid[g] = is_tx & valid_q & drain_valid;
      assign sie_tx_word[g] = '{last: (fcount == CW'(1)), single: head.single, data: head.data};
      assign tx_pop = sie_tx_valid[g] & sie_tx_ready[g];
      assign tx_done = tx_pop & (fcount == CW'(1));

      // In 8-bit mode a word is read a byte at a time.
      assign rx_pop = data_rd & (~narrow | half_q | head.single);
      assign head_data = cfg.byte_swap ? {head.data[7:0], head.data[15:8]} : head.data;
      assign data_word = narrow ? {8'h00, (half_q ? head.data[15:8] : head.data[7:0])}
                                : head_data;

      // Receive clear needs valid set; transmit clear always acts.
      assign clear_req = ctrl_wr & bus_wdata[dma_port_pkg::CLEAR_BIT] & (is_tx | valid_q);
      assign flush = clear_req;
      assign force_done = is_tx & ((ctrl_wr & bus_wdata[dma_port_pkg::VALID_BIT])
                                   | (data_wr & terminal_count_in[g]));
      assign fill_done = is_tx & data_wr & (fcount == CW'(FIFO_DEPTH - 1));

      port_fifo #(
         .WIDTH(FW),
         .DEPTH(FIFO_DEPTH),
         .CNT_W(CW)
      ) fifo_u (
         .clk_sys(clk_sys),
         .nrst(nrst),
         .flush(flush),
         .in_valid(fill_valid),
         .in_ready(fill_ready),
         .in_data(fill_word),
         .out_valid(drain_valid),
         .out_ready(drain_ready),
         .out_data(head),
         .count(fcount)
      );

      // Buffer-valid: a forced completion written with a clear still sets it.
      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            valid_q <= 1'b0;
         end else if (is_tx) begin
            if (force_done || fill_done) begin
               valid_q <= 1'b1;
            end else if (flush || tx_done) begin
               valid_q <= 1'b0;
            end
         end else begin
            if (rx_push && sie_rx_word[g].last) begin
               valid_q <= 1'b1;
            end else if (flush) begin
               valid_q <= 1'b0;
            end
         end
      end

      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            half_q <= 1'b0;
         end else if (flush || rx_pop) begin
            half_q <= 1'b0;
         end else if (data_rd) begin
            half_q <= 1'b1;
         end
      end

      assign push_bytes = rx_push ? (sie_rx_word[g].single ? LW'(1) : LW'(2)) : LW'(0);
      assign pop_bytes = !data_rd ? LW'(0) :
                         (narrow || head.single) ? LW'(1) : LW'(2);

      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            len_q <= '0;
         end else if (flush) begin
            len_q <= '0;
         end else begin
            len_q <= len_q + push_bytes - pop_bytes;
         end
      end

      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            txn_en_q <= 1'b0;
            txn_clr_q <= 1'b0;
         end else begin
            txn_clr_q <= ctrl_wr & bus_wdata[dma_port_pkg::TXN_CLEAR_BIT];
            if (ctrl_wr) begin
               txn_en_q <= bus_wdata[dma_port_pkg::TXN_ENABLE_BIT];
            end
         end
      end

      // Timing bit set: flag at packet completion. Clear: flag after the last receive read.
      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            ready_q <= 1'b0;
         end else if (cfg.ready_flag_timing) begin
            ready_q <= (rx_push & sie_rx_word[g].last & ~valid_q) | tx_done;
         end else begin
            ready_q <= rx_pop & (fcount == CW'(1)) & valid_q;
         end
      end

      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            access_q <= 1'b0;
         end else begin
            access_q <= data_wr | data_rd;
         end
      end

      assign txn_count_enable[g] = txn_en_q;
      assign txn_count_clear[g] = txn_clr_q;
      assign buffer_ready_flag[g] = ready_q;
      // Cycle steal drops the request for the cycle after each access; burst holds it.
      assign dma_request[g] = cfg.dma_request_enable & ~not_ready
                              & ~(~cfg.burst_select & access_q);

      // Clear bits always read 0; length reports receive endpoints only.
      assign ctrl_word = {1'b0, txn_en_q, valid_q, 1'b0, not_ready,
                          (is_tx ? LW'(0) : len_q)};

      always_comb begin
         if (hit_ctrl) begin
            rd_val[g] = ctrl_word;
         end else if (data_rd) begin
            rd_val[g] = data_word;
         end else begin
            rd_val[g] = 16'h0000;
         end
      end
   end

endmodule : dma_fifo_port_access

// File: bench/dma_fifo_port_access_sva.sv
// Concurrent checks on port 0 and on the shared read data of the DMA-side port access block.
`timescale 1ns/1ps
module dma_port_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Register bus
   input wire logic bus_cs,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic [7:0] bus_addr,
   input wire logic [1:0] bus_be,
   input wire logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   // Configuration and outputs
   input dma_port_pkg::port_cfg_t port_cfg [2],
   input wire logic bus_width_strap,
   input wire logic [1:0] byte_mode_readback,
   input wire logic [1:0] dma_request,
   input wire logic [1:0] txn_count_enable,
   input wire logic [1:0] txn_count_clear
);
   logic cw;
   logic cr;
   logic da;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   assign cw = bus_cs && bus_wr && bus_be[1] && bus_addr == dma_port_pkg::PORT0_CONTROL_OFS;
   assign cr = bus_cs && bus_rd && bus_addr == dma_port_pkg::PORT0_CONTROL_OFS;
   assign da = bus_cs && (bus_rd || bus_wr) && bus_addr == dma_port_pkg::PORT0_DATA_OFS;
   a_clear_pulse: assert property (cw && bus_wdata[15] |=> txn_count_clear[0])
      else $error("clear pulse missing");
   a_clear_cause: assert property (txn_count_clear[0] |-> $past(cw && bus_wdata[15]))
      else $error("clear pulse without write");
   a_enable_follow: assert property (cw |=> txn_count_enable[0] == $past(bus_wdata[14]))
      else $error("count enable mismatch");
   a_ctl_zero: assert property (cr |=> !bus_rdata[15] && !bus_rdata[12])
      else $error("command bit read as one");
   a_rdata_hold: assert property (!(bus_cs && bus_rd) |=> $stable(bus_rdata))
      else $error("read data moved without read");
   a_strap_mode: assert property (byte_mode_readback[0] == (port_cfg[0].byte_mode && bus_width_strap))
      else $error("byte mode readback wrong");
   a_req_enable: assert property (dma_request[0] |-> port_cfg[0].dma_request_enable)
      else $error("request while disabled");
   a_steal_drop: assert property (da && !port_cfg[0].burst_select |=> !dma_request[0])
      else $error("request kept after access");
   a_ready_read: assert property (cr && dma_request[0] |=> !bus_rdata[11])
      else $error("not ready set while requesting");
   c_clear: cover property (cw && bus_wdata[15]);
   c_req: cover property ($rose(dma_request[0]));
   c_steal: cover property (da && dma_request[0]);
endmodule : dma_port_sva

// File: bench/sie_model.sv
// Serial engine stand-in: sends receive words until n_rx have gone, the last one marked, and drains transmit words.
`timescale 1ns/1ps
module sie_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Test control
   input wire logic [3:0] n_rx,
   input wire logic stall,
   // Streams
   output logic rx_valid,
   output dma_port_pkg::stream_word_t rx_word,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input dma_port_pkg::stream_word_t tx_word,
   output logic tx_ready
);
   dma_port_pkg::stream_word_t got [16];
   logic [3:0] sent;
   int n_got;
   assign rx_valid = nrst && sent < n_rx;
   // Idle data is inverted so a stale word never passes for a fresh one.
   assign rx_word = '{last: sent == n_rx - 4'h1, single: 1'h0,
                      data: (16'h0201 + 16'h0202 * sent) ^ {16{!rx_valid}}};
   assign tx_ready = !stall;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sent <= 4'h0;
         n_got <= 0;
      end else begin
         if (rx_valid && rx_ready) sent <= sent + 4'h1;
         if (tx_valid && tx_ready) begin
            got[n_got] <= tx_word;
            n_got <= n_got + 1;
         end
      end
   end
endmodule : sie_model

// File: bench/tb_dma_fifo_port_access.sv
// Self-checking testbench for the DMA-side port access block.
`timescale 1ns/1ps
module tb_dma_fifo_port_access;
   localparam logic [7:0] C0 = dma_port_pkg::PORT0_CONTROL_OFS;
   localparam logic [7:0] D0 = dma_port_pkg::PORT0_DATA_OFS;
   localparam logic [7:0] C1 = dma_port_pkg::PORT1_CONTROL_OFS;
   localparam logic [7:0] D1 = dma_port_pkg::PORT1_DATA_OFS;
   logic clk_sys, nrst, bus_cs, bus_rd, bus_wr, bus_width_strap, stall;
   logic [7:0] bus_addr;
   logic [1:0] bus_be, tc_in, dreq, cnt_en, cnt_clr, bmr, rdy;
   logic [15:0] bus_wdata, bus_rdata;
   logic [6:0] ep_mode, ep_dir;
   logic [3:0] n_rx;
   dma_port_pkg::port_cfg_t port_cfg [2];
   wire [1:0] rx_v, rx_r, tx_v, tx_r;
   wire dma_port_pkg::stream_word_t rx_w [2];
   wire dma_port_pkg::stream_word_t tx_w [2];
   int num_errors = 0;
   int n_checks = 0;
   int n_rdy0 = 0;
   int n_rdy1 = 0;

   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   // The buffer-ready flag is a one-cycle pulse, so it is counted rather than sampled.
   always @(posedge clk_sys) begin
      if (rdy[0]) n_rdy0 <= n_rdy0 + 1;
      if (rdy[1]) n_rdy1 <= n_rdy1 + 1;
   end

   dma_fifo_port_access #(.FIFO_DEPTH(8)) i_dut (
      .clk_sys(clk_sys), .nrst(nrst), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .port_cfg(port_cfg), .bus_width_strap(bus_width_strap), .endpoint_byte_mode(ep_mode),
      .endpoint_direction(ep_dir), .byte_mode_readback(bmr), .terminal_count_in(tc_in),
      .dma_request(dreq), .txn_count_enable(cnt_en), .txn_count_clear(cnt_clr),
      .buffer_ready_flag(rdy), .sie_rx_valid(rx_v), .sie_rx_word(rx_w), .sie_rx_ready(rx_r),
      .sie_tx_valid(tx_v), .sie_tx_word(tx_w), .sie_tx_ready(tx_r));
   sie_model i_sie0 (.clk_sys(clk_sys), .nrst(nrst), .n_rx(n_rx), .stall(1'h0),
      .rx_valid(rx_v[0]), .rx_word(rx_w[0]), .rx_ready(rx_r[0]),
      .tx_valid(tx_v[0]), .tx_word(tx_w[0]), .tx_ready(tx_r[0]));
   sie_model i_sie1 (.clk_sys(clk_sys), .nrst(nrst), .n_rx(4'h0), .stall(stall),
      .rx_valid(rx_v[1]), .rx_word(rx_w[1]), .rx_ready(rx_r[1]),
      .tx_valid(tx_v[1]), .tx_word(tx_w[1]), .tx_ready(tx_r[1]));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [1:0] be,
                      input logic [15:0] d);
      bus_cs <= 1'h1;
      bus_rd <= !w;
      bus_wr <= w;
      bus_addr <= a;
      bus_be <= be;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_cs <= 1'h0;
      bus_rd <= 1'h0;
      bus_wr <= 1'h0;
      // One idle edge keeps the next call from re-driving the strobes in this time step.
      @(posedge clk_sys);
   endtask : bus

   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      bus(1'h0, a, 2'h3, 16'h0000);
      chk(bus_rdata, e);
   endtask : rdc

   task automatic wait_got(input int n);
      for (int i = 0; i < 200 && i_sie1.n_got < n; i++) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
   endtask : wait_got

   task automatic t_reset;
      rdc(C0, dma_port_pkg::CONTROL_RESET);
      rdc(C1, dma_port_pkg::CONTROL_RESET);
      port_cfg[0].dma_endpoint_select <= 4'h1;
      port_cfg[1].dma_endpoint_select <= 4'h2;
      @(posedge clk_sys);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_count;
      fork
         bus(1'h1, C0, 2'h3, 16'hC000);
         begin
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk(cnt_clr[0], 1'h1);
            chk(cnt_en[0], 1'h1);
         end
      join
      @(posedge clk_sys);
      rdc(C0, 16'h4800);
      bus(1'h1, C0, 2'h1, 16'h0000);
      rdc(C0, 16'h4800);
      bus(1'h1, C0, 2'h3, 16'h0000);
      rdc(C0, 16'h0800);
      $display("t_count done");
   endtask : t_count

   task automatic t_rx;
      bus(1'h1, C0, 2'h3, 16'h2000);
      rdc(C0, 16'h0800);
      port_cfg[0].dma_request_enable <= 1'h1;
      n_rx <= 4'h3;
      for (int i = 0; i < 50 && i_sie0.sent < 3; i++) @(posedge clk_sys);
      @(posedge clk_sys);
      chk(dreq[0], 1'h1);
      rdc(C0, 16'h2006);
      rdc(D0, 16'h0201);
      rdc(C0, 16'h2004);
      rdc(D0, 16'h0403);
      rdc(D0, 16'h0605);
      rdc(C0, 16'h2800);
      bus(1'h1, C0, 2'h3, 16'h1000);
      rdc(C0, 16'h0800);
      ep_mode[1] <= 1'h1;
      n_rx <= 4'h5;
      for (int i = 0; i < 50 && i_sie0.sent < 5; i++) @(posedge clk_sys);
      @(posedge clk_sys);
      rdc(C0, 16'h2004);
      rdc(D0, 16'h0007);
      rdc(D0, 16'h0008);
      rdc(C0, 16'h2002);
      rdc(D0, 16'h0009);
      rdc(D0, 16'h000A);
      rdc(C0, 16'h2800);
      chk(n_rdy0, 2);
      bus(1'h1, C0, 2'h3, 16'h1000);
      rdc(C0, 16'h0800);
      $display("t_rx done");
   endtask : t_rx

   task automatic t_tx;
      stall <= 1'h1;
      port_cfg[1].ready_flag_timing <= 1'h1;
      rdc(C1, 16'h0000);
      bus(1'h1, D1, 2'h3, 16'h1234);
      port_cfg[1].byte_swap <= 1'h0;
      repeat (6) bus(1'h1, D1, 2'h3, 16'h0A0B);
      bus(1'h1, D1, 2'h1, 16'h0056);
      rdc(C1, 16'h2800);
      bus(1'h1, D1, 2'h3, 16'hFFFF);
      stall <= 1'h0;
      wait_got(8);
      chk(i_sie1.n_got, 8);
      chk(n_rdy1, 1);
      chk(i_sie1.got[0], 18'h03412);
      chk({i_sie1.got[7].last, i_sie1.got[7].single, i_sie1.got[7].data[7:0]}, 10'h356);
      rdc(C1, 16'h0000);
      bus(1'h1, D1, 2'h3, 16'hBEEF);
      bus(1'h1, C1, 2'h3, 16'h2000);
      wait_got(9);
      chk(i_sie1.got[8], 18'h2BEEF);
      tc_in[1] <= 1'h1;
      bus(1'h1, D1, 2'h2, 16'hAB00);
      tc_in[1] <= 1'h0;
      wait_got(10);
      chk(i_sie1.got[9], 18'h300AB);
      chk(n_rdy1, 3);
      $display("t_tx done");
   endtask : t_tx

   task automatic t_mode;
      port_cfg[0].byte_mode <= 1'h1;
      bus_width_strap <= 1'h0;
      @(negedge clk_sys);
      chk(bmr[0], 1'h0);
      @(posedge clk_sys);
      bus_width_strap <= 1'h1;
      @(negedge clk_sys);
      chk(bmr[0], 1'h1);
      @(posedge clk_sys);
      $display("t_mode done");
   endtask : t_mode

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   initial begin
      nrst = 1'h0;
      {bus_cs, bus_rd, bus_wr, stall, tc_in, n_rx} = '0;
      {bus_addr, bus_be, bus_wdata} = '0;
      port_cfg[0] = '0;
      port_cfg[1] = '0;
      port_cfg[1].byte_swap = 1'h1;
      bus_width_strap = 1'h1;
      ep_mode = 7'h00;
      ep_dir = 7'h04;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'h1;
      t_reset;
      t_count;
      t_rx;
      t_tx;
      t_mode;
      test_done;
   end

   // The whole run needs about 120 cycles, so this only trips on a hang.
   initial begin
      repeat (3000) @(posedge clk_sys);
      num_errors++;
      test_done;
   end
endmodule : tb_dma_fifo_port_access

bind dma_fifo_port_access dma_port_sva i_sva (
   .clk_sys(clk_sys), .nrst(nrst), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr),
   .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .port_cfg(port_cfg), .bus_width_strap(bus_width_strap),
   .byte_mode_readback(byte_mode_readback), .dma_request(dma_request),
   .txn_count_enable(txn_count_enable), .txn_count_clear(txn_count_clear));
